/* rtl/core_sfr_pkg.sv */
`default_nettype none
package core_sfr_pkg;

  // special register addresses
  localparam logic [7:0] ADDR_STACK_TOP   = 8'h81;
  localparam logic [7:0] ADDR_PTR_LOW     = 8'h82;
  localparam logic [7:0] ADDR_PTR_HIGH    = 8'h83;
  localparam logic [7:0] ADDR_STATUS      = 8'hd0;
  localparam logic [7:0] ADDR_WORK        = 8'he0;
  localparam logic [7:0] ADDR_SECOND      = 8'hf0;
  localparam logic [7:0] ADDR_PTR_SELECT  = 8'hf8;

  // field positions
  localparam int BIT_PTR_SELECT = 0;
  localparam int BIT_CARRY      = 7;
  localparam int BIT_HALF_CARRY = 6;
  localparam int BIT_USER_ZERO  = 5;
  localparam int BIT_BANK_HI    = 4;
  localparam int BIT_BANK_LO    = 3;
  localparam int BIT_RANGE      = 2;
  localparam int BIT_USER_ONE   = 1;
  localparam int BIT_PARITY     = 0;

  // reset values
  localparam logic [7:0]  RST_STACK_TOP  = 8'h07;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [15:0] RST_WORD       = 16'h0000;
  localparam logic        RST_PTR_SELECT = 1'b0;

  typedef enum logic [4:0] {
    OP_NONE, OP_LOAD_WORK, OP_ADD, OP_ADDC, OP_SUBB, OP_MUL, OP_DIV,
    OP_AND, OP_OR, OP_XOR, OP_CLR_CARRY, OP_SET_CARRY, OP_CPL_CARRY,
    OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_RETI, OP_PTR_INC, OP_PTR_LOAD
  } op_kind_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    op_kind_t    kind;
    logic [7:0]  operand;
    logic [15:0] word;
  } core_op_t;

  typedef struct packed {
    logic       wr_work;
    logic       wr_second;
    logic       wr_carry;
    logic       wr_half;
    logic       wr_range;
    logic [7:0] work;
    logic [7:0] second;
    logic       carry;
    logic       half;
    logic       range;
  } alu_out_t;

endpackage
`default_nettype wire

/* rtl/core_alu_flags.sv */
`default_nettype none
module core_alu_flags (
  // operation
  input  wire core_sfr_pkg::op_kind_t kind_i,
  input  wire logic [7:0]             work_i,
  input  wire logic [7:0]             second_i,
  input  wire logic [7:0]             operand_i,
  input  wire logic                   carry_i,
  // result
  output core_sfr_pkg::alu_out_t      res_o
);
  import core_sfr_pkg::*;

  logic [8:0]  sum;
  logic [4:0]  nib;
  logic [15:0] prod;
  logic        cin;

  always_comb begin
    res_o = '0;
    cin   = (kind_i == OP_ADD) ? 1'b0 : carry_i;
    sum   = '0;
    nib   = '0;
    prod  = '0;
    case (kind_i)
      OP_LOAD_WORK: begin
        res_o.wr_work = 1'b1;
        res_o.work    = operand_i;
      end
      OP_ADD, OP_ADDC: begin
        sum = {1'b0, work_i} + {1'b0, operand_i} + {8'h00, cin};
        nib = {1'b0, work_i[3:0]} + {1'b0, operand_i[3:0]} + {4'h0, cin};
        res_o = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, sum[7:0], 8'h00, sum[8], nib[4],
                  (work_i[7] == operand_i[7]) && (sum[7] != work_i[7])};
      end
      OP_SUBB: begin
        sum = {1'b0, work_i} - {1'b0, operand_i} - {8'h00, cin};
        nib = {1'b0, work_i[3:0]} - {1'b0, operand_i[3:0]} - {4'h0, cin};
        res_o = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, sum[7:0], 8'h00, sum[8], nib[4],
                  (work_i[7] != operand_i[7]) && (sum[7] != work_i[7])};
      end
      OP_MUL: begin
        prod  = work_i * second_i;
        res_o = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, prod[7:0], prod[15:8], 1'b0, 1'b0,
                  |prod[15:8]};
      end
      OP_DIV: begin
        // divide by zero leaves both operands untouched
        res_o.wr_carry = 1'b1;
        res_o.wr_range = 1'b1;
        res_o.range    = (second_i == 8'h00);
        if (second_i != 8'h00) begin
          res_o.wr_work   = 1'b1;
          res_o.wr_second = 1'b1;
          res_o.work      = work_i / second_i;
          res_o.second    = work_i % second_i;
        end
      end
      OP_AND: begin
        res_o.wr_work = 1'b1;
        res_o.work    = work_i & operand_i;
      end
      OP_OR: begin
        res_o.wr_work = 1'b1;
        res_o.work    = work_i | operand_i;
      end
      OP_XOR: begin
        res_o.wr_work = 1'b1;
        res_o.work    = work_i ^ operand_i;
      end
      OP_CLR_CARRY: res_o.wr_carry = 1'b1;
      OP_SET_CARRY: begin
        res_o.wr_carry = 1'b1;
        res_o.carry    = 1'b1;
      end
      OP_CPL_CARRY: begin
        res_o.wr_carry = 1'b1;
        res_o.carry    = !carry_i;
      end
      default: ;
    endcase
  end

endmodule
`default_nettype wire

/* rtl/memory_pointer_pair.sv */
`default_nettype none
module memory_pointer_pair (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // control
  input  wire logic        sel_i,
  input  wire logic        next_sel_i,
  input  wire logic        we_low_i,
  input  wire logic        we_high_i,
  input  wire logic        inc_i,
  input  wire logic        load_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [15:0] load_word_i,
  // active pointer, registered
  output logic [15:0]      active_o
);
  import core_sfr_pkg::*;

  logic [1:0][15:0] ptr;
  logic [1:0][15:0] next_ptr;

  for (genvar i = 0; i < 2; i++) begin : g_entry
    always_comb begin
      next_ptr[i] = ptr[i];
      if (sel_i == 1'(i)) begin
        if (inc_i) begin
          next_ptr[i] = ptr[i] + 16'h0001;
        end
        if (load_i) begin
          next_ptr[i] = load_word_i;
        end
        if (we_low_i) begin
          next_ptr[i][7:0] = wdata_i;
        end
        if (we_high_i) begin
          next_ptr[i][15:8] = wdata_i;
        end
      end
    end
  end

  // read register tracks the selection that takes effect next
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr      <= '0;
      active_o <= RST_WORD;
    end else begin
      ptr      <= next_ptr;
      active_o <= next_ptr[next_sel_i];
    end
  end

endmodule
`default_nettype wire

/* rtl/cpu_core_special_registers.sv */
`default_nettype none
module cpu_core_special_registers (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // special register access
  input  wire core_sfr_pkg::sfr_req_t sfr_req_i,
  output logic [7:0]                  sfr_rdata_o,
  // instruction operations
  input  wire logic                   op_valid_i,
  input  wire core_sfr_pkg::core_op_t op_i,
  output logic                        busy_o,
  // stack memory
  output logic                        stack_we_o,
  output logic                        stack_rd_o,
  output logic [7:0]                  stack_addr_o,
  output logic [7:0]                  stack_wdata_o,
  input  wire logic [7:0]             stack_rdata_i,
  // program counter restore
  output logic [15:0]                 pc_restore_o,
  output logic                        pc_restore_valid_o,
  // core state
  output logic [7:0]                  work_o,
  output logic [7:0]                  second_o,
  output logic [7:0]                  stack_top_o,
  output logic [7:0]                  status_o,
  output logic [15:0]                 pointer_addr_o,
  output logic [7:0]                  bank_base_o
);
  import core_sfr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CALL_HIGH, ST_RET_LOW, ST_RET_CAP_HIGH, ST_RET_CAP_LOW
  } stack_state_t;

  logic [7:0]   alu_work_register;
  logic [7:0]   second_operand_register;
  logic [7:0]   stack_top_pointer;
  logic [7:0]   program_status_word;
  logic         pointer_bank_select;
  logic [7:0]   next_work;
  logic [7:0]   next_second;
  logic [7:0]   next_status;
  logic         next_select;
  logic         op_go;
  logic         sfr_wr_work;
  logic         sfr_wr_second;
  logic         sfr_wr_status;
  logic         sfr_wr_select;
  logic         sfr_wr_stack;
  logic [7:0]   held_high;
  stack_state_t stack_state;
  alu_out_t     alu_res;

  assign op_go         = op_valid_i && !busy_o;
  assign sfr_wr_work   = sfr_req_i.wr && (sfr_req_i.addr == ADDR_WORK);
  assign sfr_wr_second = sfr_req_i.wr && (sfr_req_i.addr == ADDR_SECOND);
  assign sfr_wr_status = sfr_req_i.wr && (sfr_req_i.addr == ADDR_STATUS);
  assign sfr_wr_select = sfr_req_i.wr && (sfr_req_i.addr == ADDR_PTR_SELECT);
  assign sfr_wr_stack  = sfr_req_i.wr && (sfr_req_i.addr == ADDR_STACK_TOP);

  assign work_o      = alu_work_register;
  assign second_o    = second_operand_register;
  assign stack_top_o = stack_top_pointer;
  assign status_o    = program_status_word;

  core_alu_flags core_alu_flags_inst (
    .kind_i    (op_go ? op_i.kind : OP_NONE),
    .work_i    (alu_work_register),
    .second_i  (second_operand_register),
    .operand_i (op_i.operand),
    .carry_i   (program_status_word[BIT_CARRY]),
    .res_o     (alu_res)
  );

  // the active pointer addresses external data and offset fetches/jumps
  memory_pointer_pair memory_pointer_pair_inst (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .sel_i       (pointer_bank_select),
    .next_sel_i  (next_select),
    .we_low_i    (sfr_req_i.wr && (sfr_req_i.addr == ADDR_PTR_LOW)),
    .we_high_i   (sfr_req_i.wr && (sfr_req_i.addr == ADDR_PTR_HIGH)),
    .inc_i       (op_go && (op_i.kind == OP_PTR_INC)),
    .load_i      (op_go && (op_i.kind == OP_PTR_LOAD)),
    .wdata_i     (sfr_req_i.wdata),
    .load_word_i (op_i.word),
    .active_o    (pointer_addr_o)
  );

  // software write first, instruction effect overrides it
  always_comb begin
    next_work   = alu_work_register;
    next_second = second_operand_register;
    next_status = program_status_word;
    next_select = pointer_bank_select;
    if (sfr_wr_work) begin
      next_work = sfr_req_i.wdata;
    end
    if (sfr_wr_second) begin
      next_second = sfr_req_i.wdata;
    end
    if (sfr_wr_status) begin
      next_status = sfr_req_i.wdata;
    end
    if (sfr_wr_select) begin
      next_select = sfr_req_i.wdata[BIT_PTR_SELECT];
    end
    if (alu_res.wr_work) begin
      next_work = alu_res.work;
    end
    if (alu_res.wr_second) begin
      next_second = alu_res.second;
    end
    // flags only touch their own bits; user flags and bank are left alone
    if (alu_res.wr_carry) begin
      next_status[BIT_CARRY] = alu_res.carry;
    end
    if (alu_res.wr_half) begin
      next_status[BIT_HALF_CARRY] = alu_res.half;
    end
    if (alu_res.wr_range) begin
      next_status[BIT_RANGE] = alu_res.range;
    end
    // parity cannot be forced by software
    next_status[BIT_PARITY] = ^next_work;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alu_work_register       <= RST_BYTE;
      second_operand_register <= RST_BYTE;
    end else begin
      alu_work_register       <= next_work;
      second_operand_register <= next_second;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      program_status_word <= RST_BYTE;
      bank_base_o         <= RST_BYTE;
    end else begin
      program_status_word <= next_status;
      bank_base_o         <= {3'b000, next_status[BIT_BANK_HI:BIT_BANK_LO], 3'b000};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pointer_bank_select <= RST_PTR_SELECT;
    end else begin
      pointer_bank_select <= next_select;
    end
  end

  // reads show the value before any write in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_rdata_o <= RST_BYTE;
    end else begin
      sfr_rdata_o <= RST_BYTE;
      if (sfr_req_i.rd) begin
        case (sfr_req_i.addr)
          ADDR_WORK:       sfr_rdata_o <= alu_work_register;
          ADDR_SECOND:     sfr_rdata_o <= second_operand_register;
          ADDR_STACK_TOP:  sfr_rdata_o <= stack_top_pointer;
          ADDR_STATUS:     sfr_rdata_o <= program_status_word;
          ADDR_PTR_LOW:    sfr_rdata_o <= pointer_addr_o[7:0];
          ADDR_PTR_HIGH:   sfr_rdata_o <= pointer_addr_o[15:8];
          ADDR_PTR_SELECT: sfr_rdata_o <= {7'h00, pointer_bank_select};
          default:         sfr_rdata_o <= RST_BYTE;
        endcase
      end
    end
  end

  // stack sequencer; the pointer always names the newest stored byte
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stack_state        <= ST_IDLE;
      stack_top_pointer  <= RST_STACK_TOP;
      stack_we_o         <= 1'b0;
      stack_rd_o         <= 1'b0;
      stack_addr_o       <= RST_BYTE;
      stack_wdata_o      <= RST_BYTE;
      held_high          <= RST_BYTE;
      pc_restore_o       <= RST_WORD;
      pc_restore_valid_o <= 1'b0;
      busy_o             <= 1'b0;
    end else begin
      stack_we_o         <= 1'b0;
      stack_rd_o         <= 1'b0;
      pc_restore_valid_o <= 1'b0;
      if (sfr_wr_stack) begin
        stack_top_pointer <= sfr_req_i.wdata;
      end
      unique case (stack_state)
        ST_IDLE: begin
          if (op_go) begin
            case (op_i.kind)
              OP_PUSH: begin
                stack_top_pointer <= stack_top_pointer + 8'h01;
                stack_addr_o      <= stack_top_pointer + 8'h01;
                stack_wdata_o     <= op_i.operand;
                stack_we_o        <= 1'b1;
              end
              OP_POP: begin
                stack_top_pointer <= stack_top_pointer - 8'h01;
                stack_addr_o      <= stack_top_pointer;
                stack_rd_o        <= 1'b1;
              end
              OP_CALL: begin
                // low byte first, so the high byte ends on top
                stack_top_pointer <= stack_top_pointer + 8'h01;
                stack_addr_o      <= stack_top_pointer + 8'h01;
                stack_wdata_o     <= op_i.word[7:0];
                stack_we_o        <= 1'b1;
                held_high         <= op_i.word[15:8];
                stack_state       <= ST_CALL_HIGH;
                busy_o            <= 1'b1;
              end
              OP_RET, OP_RETI: begin
                stack_top_pointer <= stack_top_pointer - 8'h01;
                stack_addr_o      <= stack_top_pointer;
                stack_rd_o        <= 1'b1;
                stack_state       <= ST_RET_LOW;
                busy_o            <= 1'b1;
              end
              default: ;
            endcase
          end
        end
        ST_CALL_HIGH: begin
          stack_top_pointer <= stack_top_pointer + 8'h01;
          stack_addr_o      <= stack_top_pointer + 8'h01;
          stack_wdata_o     <= held_high;
          stack_we_o        <= 1'b1;
          stack_state       <= ST_IDLE;
          busy_o            <= 1'b0;
        end
        ST_RET_LOW: begin
          stack_top_pointer <= stack_top_pointer - 8'h01;
          stack_addr_o      <= stack_top_pointer;
          stack_rd_o        <= 1'b1;
          stack_state       <= ST_RET_CAP_HIGH;
        end
        ST_RET_CAP_HIGH: begin
          held_high   <= stack_rdata_i;
          stack_state <= ST_RET_CAP_LOW;
        end
        ST_RET_CAP_LOW: begin
          pc_restore_o       <= {held_high, stack_rdata_i};
          pc_restore_valid_o <= 1'b1;
          stack_state        <= ST_IDLE;
          busy_o             <= 1'b0;
        end
        default: begin
          stack_state <= ST_IDLE;
          busy_o      <= 1'b0;
        end
      endcase
    end
  end

  // checks
  logic       add_carry_chk;
  logic [7:0] add_sum_chk;
  logic [1:0] user_flags_chk;
  logic       select_bit_chk;

  assign {add_carry_chk, add_sum_chk} = {1'b0, alu_work_register} + {1'b0, op_i.operand};
  assign user_flags_chk = {program_status_word[BIT_USER_ZERO], program_status_word[BIT_USER_ONE]};
  assign select_bit_chk = sfr_req_i.wdata[BIT_PTR_SELECT];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_add_result;
    op_go && (op_i.kind == OP_ADD) && !sfr_req_i.wr
      |=> (alu_work_register == $past(add_sum_chk))
          && (program_status_word[BIT_CARRY] == $past(add_carry_chk));
  endproperty
  a_add_result: assert property (p_add_result)
    else $error("add result or carry wrong");
  property p_mul_operands;
    op_go && (op_i.kind == OP_MUL) && !sfr_req_i.wr
      |=> ({second_operand_register, alu_work_register}
           == $past(alu_work_register) * $past(second_operand_register))
          && !program_status_word[BIT_CARRY];
  endproperty
  a_mul_operands: assert property (p_mul_operands)
    else $error("multiply product or carry wrong");
  property p_parity_tracks;
    program_status_word[BIT_PARITY] == ^alu_work_register;
  endproperty
  a_parity_tracks: assert property (p_parity_tracks)
    else $error("parity flag disagrees with work register");
  property p_push_top;
    op_go && (op_i.kind == OP_PUSH) && !sfr_wr_stack
      |=> stack_we_o && (stack_top_pointer == $past(stack_top_pointer) + 8'h01)
          && (stack_addr_o == stack_top_pointer);
  endproperty
  a_push_top: assert property (p_push_top)
    else $error("push did not store at the incremented top");
  property p_pop_top;
    op_go && (op_i.kind == OP_POP) && !sfr_wr_stack
      |=> stack_rd_o && (stack_addr_o == $past(stack_top_pointer))
          && (stack_top_pointer == $past(stack_top_pointer) - 8'h01);
  endproperty
  a_pop_top: assert property (p_pop_top)
    else $error("pop did not read the top and decrement");
  property p_call_saves;
    op_go && (op_i.kind == OP_CALL) && !sfr_wr_stack
      |=> stack_we_o && (stack_wdata_o == $past(op_i.word[7:0])) && busy_o
      ##1 stack_we_o && (stack_wdata_o == $past(held_high))
          && (stack_top_pointer == $past(stack_top_pointer, 2) + 8'h02);
  endproperty
  a_call_saves: assert property (p_call_saves)
    else $error("call did not save both bytes on the stack");
  property p_return_restores;
    op_go && ((op_i.kind == OP_RET) || (op_i.kind == OP_RETI))
      |=> stack_rd_o ##1 stack_rd_o ##1 !pc_restore_valid_o ##1 pc_restore_valid_o && !busy_o;
  endproperty
  a_return_restores: assert property (p_return_restores)
    else $error("return did not restore within four cycles");
  property p_user_flags_kept;
    !sfr_wr_status |=> user_flags_chk == $past(user_flags_chk);
  endproperty
  a_user_flags_kept: assert property (p_user_flags_kept)
    else $error("user flag changed without a software write");

  property p_bank_base;
    bank_base_o == 8'h08 * 8'(program_status_word[BIT_BANK_HI:BIT_BANK_LO]);
  endproperty
  a_bank_base: assert property (p_bank_base)
    else $error("bank base does not follow bank bits");

  property p_select_write;
    sfr_wr_select |=> pointer_bank_select == $past(select_bit_chk);
  endproperty
  a_select_write: assert property (p_select_write)
    else $error("pointer select not taken from write data");

  property p_pointer_low_write;
    sfr_req_i.wr && (sfr_req_i.addr == ADDR_PTR_LOW) && !op_go
      |=> pointer_addr_o[7:0] == $past(sfr_req_i.wdata);
  endproperty
  a_pointer_low_write: assert property (p_pointer_low_write)
    else $error("active pointer low byte not written");

endmodule
`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import core_sfr_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  sfr_req_t    req   = '0;
  logic        op_valid = 1'b0;
  core_op_t    op    = '{OP_NONE, 8'h00, 16'h0000};
  logic [7:0]  stack_rdata = 8'h00;
  logic [7:0]  rdata, work, second, top, status, bank, saddr, swdata, q;
  logic [15:0] pc, ptr;
  logic        busy, swe, srd, pcv;
  int          bad_count = 0;
  int          compares = 0;
  always #2 clk_i = ~clk_i;
  cpu_core_special_registers cpu_core_special_registers_inst (
    .clk_i(clk_i), .rst_i(rst_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
    .op_valid_i(op_valid), .op_i(op), .busy_o(busy), .stack_we_o(swe),
    .stack_rd_o(srd), .stack_addr_o(saddr), .stack_wdata_o(swdata),
    .stack_rdata_i(stack_rdata), .pc_restore_o(pc), .pc_restore_valid_o(pcv),
    .work_o(work), .second_o(second), .stack_top_o(top), .status_o(status),
    .pointer_addr_o(ptr), .bank_base_o(bank));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // one task for both directions: rd is raised only when not writing
  task automatic sfr(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{a, w, ~w, d};
    @(posedge clk_i);
    req <= '0;
    #1 q = rdata;
  endtask
  task automatic run(input op_kind_t k, input logic [7:0] o, input logic [15:0] wd);
    @(posedge clk_i);
    op_valid <= 1'b1;
    op <= '{k, o, wd};
    @(posedge clk_i);
    op_valid <= 1'b0;
    #1;
  endtask
  task automatic wrap_up;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic t_reset;
    chk("top", top, 8'h07);
    chk("status", status, 8'h00);
    chk("ptr", ptr, 16'h0000);
    chk("busy", busy, 1'b0);
  endtask
  task automatic t_work;
    sfr(ADDR_WORK, 1'b1, 8'h55);
    chk("parity", status[0], 1'b0);
    sfr(ADDR_WORK, 1'b0, 8'h00);
    chk("work", q, 8'h55);
    sfr(ADDR_WORK, 1'b1, 8'h54);
    chk("parity", status[0], 1'b1);
    sfr(ADDR_SECOND, 1'b1, 8'h3c);
    sfr(ADDR_SECOND, 1'b0, 8'h00);
    chk("second", q, 8'h3c);
  endtask
  // parity written as 0 while work holds odd ones: must still read 1
  task automatic t_status;
    for (int i = 0; i < 4; i++) begin
      sfr(ADDR_STATUS, 1'b1, 8'h22 | 8'(i * 8));
      chk("bank", bank, 8'(i * 8));
      chk("status", status, 8'h23 | 8'(i * 8));
    end
  endtask
  task automatic t_pointer;
    sfr(ADDR_PTR_LOW, 1'b1, 8'h34);
    sfr(ADDR_PTR_HIGH, 1'b1, 8'h12);
    chk("ptr", ptr, 16'h1234);
    sfr(ADDR_PTR_SELECT, 1'b1, 8'hff);
    chk("ptr", ptr, 16'h0000);
    sfr(ADDR_PTR_SELECT, 1'b0, 8'h00);
    chk("select", q, 8'h01);
    sfr(ADDR_PTR_LOW, 1'b1, 8'hcd);
    sfr(ADDR_PTR_HIGH, 1'b1, 8'hab);
    run(OP_PTR_INC, 8'h00, 16'h0000);
    chk("ptr", ptr, 16'habce);
    sfr(ADDR_PTR_SELECT, 1'b1, 8'h00);
    sfr(ADDR_PTR_LOW, 1'b0, 8'h00);
    chk("low", q, 8'h34);
    chk("ptr", ptr, 16'h1234);
  endtask
  task automatic t_stack;
    run(OP_PUSH, 8'haa, 16'h0000);
    chk("push", {swe, saddr, swdata}, {1'b1, 8'h08, 8'haa});
    chk("top", top, 8'h08);
    run(OP_POP, 8'h00, 16'h0000);
    chk("pop", {srd, saddr}, {1'b1, 8'h08});
    chk("top", top, 8'h07);
  endtask
  task automatic t_call_ret(input op_kind_t k);
    run(OP_CALL, 8'h00, 16'h1234);
    chk("call1", {swe, saddr, swdata, busy}, {1'b1, 8'h08, 8'h34, 1'b1});
    @(posedge clk_i);
    #1 chk("call2", {swe, saddr, swdata, busy}, {1'b1, 8'h09, 8'h12, 1'b0});
    run(k, 8'h00, 16'h0000);
    chk("ret1", {srd, saddr}, {1'b1, 8'h09});
    @(posedge clk_i);
    stack_rdata <= 8'h12;
    #1 chk("ret2", {srd, saddr}, {1'b1, 8'h08});
    @(posedge clk_i);
    stack_rdata <= 8'h34;
    @(posedge clk_i);
    #1 chk("pc", {pcv, pc, top}, {1'b1, 16'h1234, 8'h07});
  endtask
  task automatic t_alu;
    sfr(ADDR_STATUS, 1'b1, 8'h22);
    sfr(ADDR_WORK, 1'b1, 8'h7f);
    run(OP_ADD, 8'h01, 16'h0000);
    chk("add", {work, status}, 16'h8067);
    run(OP_ADD, 8'h80, 16'h0000);
    chk("add", {work, status}, 16'h00a6);
    run(OP_CLR_CARRY, 8'h00, 16'h0000);
    chk("clr", status, 8'h26);
    run(OP_SET_CARRY, 8'h00, 16'h0000);
    chk("set", status, 8'ha6);
    sfr(ADDR_WORK, 1'b1, 8'h20);
    sfr(ADDR_SECOND, 1'b1, 8'h10);
    run(OP_MUL, 8'h00, 16'h0000);
    chk("mul", {work, second}, 16'h0002);
    chk("mul", status, 8'h26);
    sfr(ADDR_WORK, 1'b1, 8'h07);
    sfr(ADDR_SECOND, 1'b1, 8'h02);
    run(OP_DIV, 8'h00, 16'h0000);
    chk("div", {work, second, status}, {16'h0301, 8'h22});
  endtask
  // every remaining operation kind, then divide by zero and pointer load
  task automatic t_ops;
    run(OP_LOAD_WORK, 8'h0f, 16'h0000);
    chk("load", {work, status}, 16'h0f22);
    run(OP_SET_CARRY, 8'h00, 16'h0000);
    run(OP_ADDC, 8'h01, 16'h0000);
    chk("addc", {work, status}, 16'h1162);
    run(OP_SUBB, 8'h12, 16'h0000);
    chk("subb", {work, status}, 16'hffe2);
    run(OP_CPL_CARRY, 8'h00, 16'h0000);
    chk("cpl", status, 8'h62);
    run(OP_AND, 8'h3c, 16'h0000);
    chk("and", {work, status}, 16'h3c62);
    run(OP_OR, 8'h41, 16'h0000);
    chk("or", {work, status}, 16'h7d62);
    run(OP_XOR, 8'hff, 16'h0000);
    chk("xor", {work, status}, 16'h8262);
    sfr(ADDR_SECOND, 1'b1, 8'h00);
    run(OP_DIV, 8'h00, 16'h0000);
    chk("div0", {work, second, status}, {16'h8200, 8'h66});
    run(OP_PTR_LOAD, 8'h00, 16'h5a5a);
    chk("ptrload", ptr, 16'h5a5a);
  endtask
  task automatic t_mid_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 t_reset;
    chk("work", {work, second}, 16'h0000);
    sfr(ADDR_PTR_SELECT, 1'b0, 8'h00);
    chk("select", q, 8'h00);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 t_reset;
    t_work;
    t_status;
    t_pointer;
    t_stack;
    t_call_ret(OP_RET);
    t_call_ret(OP_RETI);
    t_alu;
    t_ops;
    t_mid_reset;
    wrap_up;
  end
  // hang guard, far beyond the scenario length
  initial begin
    #50000;
    bad_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
